//--- hw/acqr_defs.svh
`ifndef ACQR_DEFS_SVH
`define ACQR_DEFS_SVH

// ****************************************
// Address windows (word indices)
// ****************************************
`define ACQR_BASE_BLK 4'hE
`define ACQR_BASE_NBLK 4'hF

// ****************************************
// Register offsets (word indices)
// ****************************************
`define ACQR_OFS_EXT_TEMP_VALUE_HI 8'h66
`define ACQR_OFS_EXT_TEMP_VALUE_LO 8'h67
`define ACQR_OFS_CURRENT_VALUE_W 8'h68
`define ACQR_OFS_CURRENT_VALUE_HI 8'h69
`define ACQR_OFS_CURRENT_VALUE_LO 8'h6A
`define ACQR_OFS_VOLTAGE_VALUE 8'h6C
`define ACQR_OFS_LOWPASS_COEF_COUNT 8'h6E
`define ACQR_OFS_PERIOD 8'h70

// ****************************************
// Reset values and fields
// ****************************************
`define ACQR_RST_LOWPASS_COEF_COUNT 4'hE
`define ACQR_RST_PERIOD 16'h0000
`define ACQR_LOWPASS_COEF_COUNT_W 4

// ****************************************
// Timing
// ****************************************
`define ACQR_BLK_WAIT 2'h2

`endif

//--- hw/acqr_pkg.sv
package acqr_pkg;

  // Register selected by a decoded offset
  typedef enum {
    REG_NONE,
    REG_EXT_TEMP_VALUE_HI,
    REG_EXT_TEMP_VALUE_LO,
    REG_CURRENT_VALUE_W,
    REG_CURRENT_VALUE_HI,
    REG_CURRENT_VALUE_LO,
    REG_VOLTAGE_VALUE,
    REG_LOWPASS_COEF_COUNT,
    REG_PERIOD
  } acqr_reg_t;

  // Which current part is held for the partner read
  typedef enum {
    LOCK_NONE,
    LOCK_LOW_HELD,
    LOCK_HIGH_HELD
  } acqr_lock_t;

  // Bus slave sequence
  typedef enum {
    BUS_IDLE,
    BUS_WAIT,
    BUS_DONE
  } acqr_bus_t;

  // Strobed 16-bit result
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } acqr_res16_t;

  // Strobed 24-bit signed current result
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } acqr_res24_t;

  // Acquisition start pulses
  typedef struct packed {
    logic current;
    logic temp;
  } acqr_start_t;

endpackage : acqr_pkg

//--- hw/acqr_trig.sv
`timescale 1ns/1ns
`default_nettype none
module acqr_trig #(
  parameter int PERIOD_W = 16
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic lowpower_acq_clock,
  input wire logic lp_mode,
  input wire logic [PERIOD_W-1:0] trigger_period,
  input wire logic current_en,
  input wire logic temp_en,
  // Start pulses
  output acqr_pkg::acqr_start_t start
);

  logic [PERIOD_W-1:0] cnt_r;
  logic hit;

  // Match against the period; zero matches every tick
  assign hit = lp_mode && lowpower_acq_clock && (cnt_r == trigger_period);

  // ****************************************
  // Trigger counter
  // ****************************************
  // Held at zero outside low-power mode so each entry starts a fresh period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (!lp_mode) begin
      cnt_r <= '0;
    end else if (hit) begin
      cnt_r <= '0;
    end else if (lowpower_acq_clock) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // ****************************************
  // Start pulses
  // ****************************************
  // One pulse per enabled channel, registered for clean timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start <= '0;
    end else begin
      start.current <= hit && current_en;
      start.temp <= hit && temp_en;
    end
  end

endmodule : acqr_trig
`default_nettype wire

//--- hw/acqr_regs.sv
// Our own choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "acqr_defs.svh"
module acqr_regs #(
  parameter int ADDR_W = 14,
  parameter logic [1:0] BLK_WAIT = `ACQR_BLK_WAIT
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic access_16b,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // New results from the channels
  input wire acqr_pkg::acqr_res16_t ext_temp_value,
  input wire acqr_pkg::acqr_res24_t current_value,
  input wire acqr_pkg::acqr_res16_t voltage_value,
  // Low-power trigger
  input wire logic lowpower_acq_clock,
  input wire logic lp_mode,
  input wire logic current_en,
  input wire logic temp_en,
  output acqr_pkg::acqr_start_t acq_start,
  // Filter setting
  output logic [`ACQR_LOWPASS_COEF_COUNT_W-1:0] lowpass_coef_count
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Map a word offset to a register. Offsets are word indices, so the
  // byte address on the bus is four times window plus offset; the two
  // lowest address bits carry no meaning and are not decoded.
  function automatic acqr_pkg::acqr_reg_t decode(input logic [7:0] ofs);
    acqr_pkg::acqr_reg_t r;
    case (ofs)
      `ACQR_OFS_EXT_TEMP_VALUE_HI: r = acqr_pkg::REG_EXT_TEMP_VALUE_HI;
      `ACQR_OFS_EXT_TEMP_VALUE_LO: r = acqr_pkg::REG_EXT_TEMP_VALUE_LO;
      `ACQR_OFS_CURRENT_VALUE_W: r = acqr_pkg::REG_CURRENT_VALUE_W;
      `ACQR_OFS_CURRENT_VALUE_HI: r = acqr_pkg::REG_CURRENT_VALUE_HI;
      `ACQR_OFS_CURRENT_VALUE_LO: r = acqr_pkg::REG_CURRENT_VALUE_LO;
      `ACQR_OFS_VOLTAGE_VALUE: r = acqr_pkg::REG_VOLTAGE_VALUE;
      `ACQR_OFS_LOWPASS_COEF_COUNT: r = acqr_pkg::REG_LOWPASS_COEF_COUNT;
      `ACQR_OFS_PERIOD: r = acqr_pkg::REG_PERIOD;
      default: r = acqr_pkg::REG_NONE;
    endcase
    return r;
  endfunction : decode

  // Check the access size allowed for each register. A size that the
  // register does not support is refused with an error rather than
  // returning part of a value, so software notices the slip at once.
  function automatic logic size_ok(input acqr_pkg::acqr_reg_t r, input logic wide);
    logic ok;
    case (r)
      acqr_pkg::REG_EXT_TEMP_VALUE_HI: ok = 1'b1;
      acqr_pkg::REG_EXT_TEMP_VALUE_LO: ok = !wide;
      acqr_pkg::REG_CURRENT_VALUE_W: ok = wide;
      acqr_pkg::REG_CURRENT_VALUE_HI: ok = !wide;
      acqr_pkg::REG_CURRENT_VALUE_LO: ok = wide;
      acqr_pkg::REG_VOLTAGE_VALUE: ok = wide;
      acqr_pkg::REG_LOWPASS_COEF_COUNT: ok = 1'b1;
      acqr_pkg::REG_PERIOD: ok = wide;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : size_ok

  // ****************************************
  // State
  // ****************************************
  // Bus sequence and the request kept from setup
  acqr_pkg::acqr_bus_t bus_r;
  acqr_pkg::acqr_bus_t bus_nxt;
  acqr_pkg::acqr_lock_t lock_r;
  acqr_pkg::acqr_reg_t sel_reg;
  acqr_pkg::acqr_reg_t cur_reg_r;
  logic [1:0] wait_r;
  // Live results and the holds for atomic current reads
  logic [15:0] ext_temp_value_r;
  logic [23:0] current_value_r;
  logic [15:0] voltage_value_r;
  logic [15:0] current_value_low_hold_r;
  logic [7:0] current_value_high_hold_r;
  // Software registers and read data
  logic [`ACQR_LOWPASS_COEF_COUNT_W-1:0] lowpass_coef_count_r;
  logic [15:0] period_r;
  logic [31:0] prdata_r;
  logic err_r;
  logic wide_r;
  // Decode and phase of the current request
  logic win_hit;
  logic win_blk;
  logic setup;
  logic done;
  logic legal;
  logic [7:0] ofs;
  logic [3:0] base;

  // ****************************************
  // Address windows
  // ****************************************
  // Word index is paddr[13:2]; upper nibble picks the window.
  // Any other window still completes, with an error, so a stray
  // access never stalls the bus.
  assign ofs = paddr[9:2];
  assign base = paddr[13:10];
  assign win_blk = (base == `ACQR_BASE_BLK);
  assign win_hit = win_blk || (base == `ACQR_BASE_NBLK);
  assign sel_reg = win_hit ? decode(ofs) : acqr_pkg::REG_NONE;
  assign legal = size_ok(sel_reg, access_16b);
  assign setup = psel && !penable && (bus_r == acqr_pkg::BUS_IDLE);
  assign done = psel && penable && (bus_r == acqr_pkg::BUS_DONE);

  // ****************************************
  // Bus sequence
  // ****************************************
  // Blocking window adds wait states, non-blocking answers at once.
  // The wait test is one or less, so a wait count of zero still gives
  // one wait state instead of hanging the bus.
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      acqr_pkg::BUS_IDLE: begin
        if (setup) begin
          bus_nxt = win_blk ? acqr_pkg::BUS_WAIT : acqr_pkg::BUS_DONE;
        end
      end
      acqr_pkg::BUS_WAIT: begin
        if (wait_r <= 2'h1) begin
          bus_nxt = acqr_pkg::BUS_DONE;
        end
      end
      acqr_pkg::BUS_DONE: begin
        if (done) begin
          bus_nxt = acqr_pkg::BUS_IDLE;
        end
      end
      default: bus_nxt = acqr_pkg::BUS_IDLE;
    endcase
  end

  // Sequence register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_r <= acqr_pkg::BUS_IDLE;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  // Wait-state counter for the blocking window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 2'h0;
    end else if (setup) begin
      wait_r <= BLK_WAIT;
    end else if (wait_r != 2'h0) begin
      wait_r <= wait_r - 2'h1;
    end
  end

  // Handshake outputs; error only shows alongside ready
  // Read data is held from setup, so it is valid whenever pready is
  assign pready = (bus_r == acqr_pkg::BUS_DONE);
  assign pslverr = pready && err_r;
  assign prdata = prdata_r;

  // Request details kept for the write at completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg_r <= acqr_pkg::REG_NONE;
      err_r <= 1'b0;
      wide_r <= 1'b0;
    end else if (setup) begin
      cur_reg_r <= sel_reg;
      err_r <= !legal;
      wide_r <= access_16b;
    end
  end

  // ****************************************
  // Result capture
  // ****************************************
  // Strobes from the channels refresh the live values. A strobe in the
  // setup cycle of a read lands after the read took its data, so that
  // read still returns the older conversion.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_temp_value_r <= 16'h0000;
      current_value_r <= 24'h000000;
      voltage_value_r <= 16'h0000;
    end else begin
      if (ext_temp_value.valid) begin
        ext_temp_value_r <= ext_temp_value.data;
      end
      if (current_value.valid) begin
        current_value_r <= current_value.data;
      end
      if (voltage_value.valid) begin
        voltage_value_r <= voltage_value.data;
      end
    end
  end

  // ****************************************
  // Atomic current read
  // ****************************************
  // Read side effects act once, in the setup cycle, so wait states
  // cannot repeat them. A refused read has no side effect.
  // Reading one part captures the other; the next read of the other
  // part returns the capture and frees the hold. Reading the same part
  // again captures afresh, so an abandoned pair never goes stale.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= acqr_pkg::LOCK_NONE;
      current_value_low_hold_r <= 16'h0000;
      current_value_high_hold_r <= 8'h00;
    end else if (setup && !pwrite && legal) begin
      case (sel_reg)
        acqr_pkg::REG_CURRENT_VALUE_W, acqr_pkg::REG_CURRENT_VALUE_HI: begin
          if (lock_r == acqr_pkg::LOCK_HIGH_HELD) begin
            lock_r <= acqr_pkg::LOCK_NONE;
          end else begin
            current_value_low_hold_r <= current_value_r[15:0];
            lock_r <= acqr_pkg::LOCK_LOW_HELD;
          end
        end
        acqr_pkg::REG_CURRENT_VALUE_LO: begin
          if (lock_r == acqr_pkg::LOCK_LOW_HELD) begin
            lock_r <= acqr_pkg::LOCK_NONE;
          end else begin
            current_value_high_hold_r <= current_value_r[23:16];
            lock_r <= acqr_pkg::LOCK_HIGH_HELD;
          end
        end
        default: lock_r <= lock_r;
      endcase
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  // Captured at setup; unused upper bits read zero
  // The current high byte is not sign-extended on a 16-bit read;
  // software extends bit 7 itself when it needs the signed value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (setup) begin
      prdata_r <= 32'h00000000;
      if (!pwrite && legal) begin
        case (sel_reg)
          acqr_pkg::REG_EXT_TEMP_VALUE_HI: begin
            if (access_16b) begin
              prdata_r[15:0] <= ext_temp_value_r;
            end else begin
              prdata_r[7:0] <= ext_temp_value_r[15:8];
            end
          end
          acqr_pkg::REG_EXT_TEMP_VALUE_LO: prdata_r[7:0] <= ext_temp_value_r[7:0];
          acqr_pkg::REG_CURRENT_VALUE_W, acqr_pkg::REG_CURRENT_VALUE_HI: begin
            // High byte comes from the hold when the low word led
            if (lock_r == acqr_pkg::LOCK_HIGH_HELD) begin
              prdata_r[7:0] <= current_value_high_hold_r;
            end else begin
              prdata_r[7:0] <= current_value_r[23:16];
            end
          end
          acqr_pkg::REG_CURRENT_VALUE_LO: begin
            if (lock_r == acqr_pkg::LOCK_LOW_HELD) begin
              prdata_r[15:0] <= current_value_low_hold_r;
            end else begin
              prdata_r[15:0] <= current_value_r[15:0];
            end
          end
          acqr_pkg::REG_VOLTAGE_VALUE: prdata_r[15:0] <= voltage_value_r;
          acqr_pkg::REG_LOWPASS_COEF_COUNT: prdata_r[`ACQR_LOWPASS_COEF_COUNT_W-1:0] <= lowpass_coef_count_r;
          acqr_pkg::REG_PERIOD: prdata_r[15:0] <= period_r;
          default: prdata_r <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // Writable registers
  // ****************************************
  // Writes land at the completing edge; result registers have no
  // write path at all, so writes there are simply dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lowpass_coef_count_r <= `ACQR_RST_LOWPASS_COEF_COUNT;
    end else if (done && pwrite && !err_r && pstrb[0] &&
                 (cur_reg_r == acqr_pkg::REG_LOWPASS_COEF_COUNT)) begin
      lowpass_coef_count_r <= pwdata[`ACQR_LOWPASS_COEF_COUNT_W-1:0];
    end
  end

  // Period takes a whole 16-bit write or nothing, so the counter
  // never compares against a half-updated value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_r <= `ACQR_RST_PERIOD;
    end else if (done && pwrite && !err_r && wide_r && (pstrb[1:0] == 2'h3) &&
                 (cur_reg_r == acqr_pkg::REG_PERIOD)) begin
      period_r <= pwdata[15:0];
    end
  end

  assign lowpass_coef_count = lowpass_coef_count_r;

  // ****************************************
  // Low-power trigger
  // ****************************************
  // Counter and start pulses live in their own module, so the period
  // compare stays apart from the bus logic and is easy to reuse
  acqr_trig #(
    .PERIOD_W(16)
  ) u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .lowpower_acq_clock(lowpower_acq_clock),
    .lp_mode(lp_mode),
    .trigger_period(period_r),
    .current_en(current_en),
    .temp_en(temp_en),
    .start(acq_start)
  );

endmodule : acqr_regs
`default_nettype wire

//--- bench/acqr_regs_checker.sv
`timescale 1ns/1ns
`default_nettype none
module acqr_regs_checker #(
  parameter int ADDR_W = 14
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic access_16b,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Trigger and filter
  input wire logic lowpower_acq_clock,
  input wire logic lp_mode,
  input wire logic current_en,
  input wire logic temp_en,
  input wire acqr_pkg::acqr_start_t acq_start,
  input wire logic [3:0] lowpass_coef_count
);
  logic setup;
  logic done;
  logic tick_cur;
  logic tick_tmp;
  // Bus phases and qualified ticks
  assign setup = psel && !penable;
  assign done = psel && penable && pready;
  assign tick_cur = lp_mode && lowpower_acq_clock && current_en;
  assign tick_tmp = lp_mode && lowpower_acq_clock && temp_en;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Bus timing and refusals
  // ****
  nblk_no_wait_a: assert property (setup && paddr[13:10] == 4'hF |=> pready)
    else $error("non-blocking access waited");
  blk_two_wait_a: assert property (setup && paddr[13:10] == 4'hE |=> !pready [*2] ##1 pready)
    else $error("blocking access wait count wrong");
  bad_window_a: assert property (done && paddr[13:11] != 3'h7 |-> pslverr)
    else $error("foreign window not refused");
  err_only_ready_a: assert property (pslverr |-> done)
    else $error("error outside completion");
  byte_low_err_a: assert property (done && paddr[9:2] == 8'h6A && !access_16b |-> pslverr)
    else $error("byte read of low word accepted");
  // ****
  // Filter count field
  // ****
  coef_upper_a: assert property (done && !pwrite && paddr[9:2] == 8'h6E |-> prdata[31:4] == 28'h0)
    else $error("coefficient upper bits not zero");
  coef_write_a: assert property (done && pwrite && !pslverr && pstrb[0]
    && paddr[9:2] == 8'h6E |=> lowpass_coef_count == $past(pwdata[3:0]))
    else $error("coefficient write lost");
  coef_hold_a: assert property (!(done && pwrite) |=> $stable(lowpass_coef_count))
    else $error("coefficient changed without write");
  // ****
  // Start pulses follow a qualified tick
  // ****
  start_cur_a: assert property (acq_start.current |-> $past(tick_cur))
    else $error("current start without tick");
  start_tmp_a: assert property (acq_start.temp |-> $past(tick_tmp))
    else $error("temperature start without tick");
endmodule : acqr_regs_checker
bind acqr_regs acqr_regs_checker #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .access_16b(access_16b), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lowpower_acq_clock(lowpower_acq_clock), .lp_mode(lp_mode), .current_en(current_en),
  .temp_en(temp_en), .acq_start(acq_start), .lowpass_coef_count(lowpass_coef_count));
`default_nettype wire

//--- bench/acqr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
module acqr_regs_tb;
  localparam logic [11:0] NB = 12'hF00;
  localparam logic [11:0] BK = 12'hE00;
  logic pclk, presetn, psel, penable, pwrite, access_16b, pready, pslverr, er;
  logic lowpower_acq_clock, lp_mode, current_en, temp_en;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, lowpass_coef_count;
  acqr_pkg::acqr_res16_t ext_temp_value, voltage_value;
  acqr_pkg::acqr_res24_t current_value;
  acqr_pkg::acqr_start_t acq_start;
  int fails = 0;
  int n_compared = 0;
  int n_cur = 0;
  int n_tmp = 0;

  acqr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .access_16b(access_16b),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_temp_value(ext_temp_value),
    .current_value(current_value), .voltage_value(voltage_value),
    .lowpower_acq_clock(lowpower_acq_clock), .lp_mode(lp_mode), .current_en(current_en),
    .temp_en(temp_en), .acq_start(acq_start), .lowpass_coef_count(lowpass_coef_count));

  // ****
  // Helpers
  // ****
  task automatic final_report();
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; pready is sampled at the rising edge, before the
  // design's registers move, and the request stands until that edge
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic sz,
                      input logic [3:0] st, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    access_16b <= sz;
    pstrb <= st;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rchk(input string what, input logic [11:0] idx, input logic sz,
                      input logic [31:0] exp, input logic e);
    xfer(1'b0, idx, sz, 4'h0, 32'h0);
    chk(what, exp, rd);
    chk(what, {31'h0, e}, {31'h0, er});
  endtask : rchk

  // New conversion on all three channels in one strobe
  task automatic load(input logic [15:0] t, input logic [23:0] c, input logic [15:0] v);
    @(posedge pclk);
    ext_temp_value <= {1'b1, t};
    current_value <= {1'b1, c};
    voltage_value <= {1'b1, v};
    @(posedge pclk);
    ext_temp_value.valid <= 1'b0;
    current_value.valid <= 1'b0;
    voltage_value.valid <= 1'b0;
  endtask : load

  // One low-power tick, then room for the start pulse to be counted
  task automatic tick();
    @(posedge pclk);
    lowpower_acq_clock <= 1'b1;
    @(posedge pclk);
    lowpower_acq_clock <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : tick

  // Clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Start pulse counters
  always @(posedge pclk) begin
    if (acq_start.current === 1'b1) n_cur <= n_cur + 1;
    if (acq_start.temp === 1'b1) n_tmp <= n_tmp + 1;
  end

  // Watchdog, far beyond the hundred and fifty or so cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    final_report();
  end

  // ****
  // Tests
  // ****
  initial begin
    {presetn, psel, penable, pwrite, access_16b, lowpower_acq_clock, lp_mode} = 7'h00;
    {current_en, temp_en} = 2'h3;
    paddr = 14'h0000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    ext_temp_value = '0;
    voltage_value = '0;
    current_value = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk("coef_rst", NB + 12'h06E, 1'b1, 32'hE, 1'b0);
    rchk("period_rst", NB + 12'h070, 1'b1, 32'h0, 1'b0);
    xfer(1'b1, BK + 12'h06E, 1'b0, 4'h1, 32'hFF);
    rchk("coef_max", BK + 12'h06E, 1'b0, 32'hF, 1'b0);
    chk("coef_pin", 32'hF, {28'h0, lowpass_coef_count});
    xfer(1'b1, NB + 12'h06E, 1'b1, 4'h1, 32'h30);
    rchk("coef_min", NB + 12'h06E, 1'b1, 32'h0, 1'b0);
    load(16'hA5C3, 24'h80FF12, 16'h8001);
    rchk("temp_word", NB + 12'h066, 1'b1, 32'hA5C3, 1'b0);
    rchk("temp_hi", BK + 12'h066, 1'b0, 32'hA5, 1'b0);
    rchk("temp_lo", NB + 12'h067, 1'b0, 32'hC3, 1'b0);
    rchk("voltage_value", NB + 12'h06C, 1'b1, 32'h8001, 1'b0);
    xfer(1'b1, NB + 12'h06C, 1'b1, 4'h3, 32'h1234);
    rchk("voltage_value_ro", NB + 12'h06C, 1'b1, 32'h8001, 1'b0);
    // Atomic pairs: a new conversion lands between the two halves
    rchk("current_value_hi_w", NB + 12'h068, 1'b1, 32'h80, 1'b0);
    load(16'hA5C3, 24'h123456, 16'h8001);
    rchk("current_value_lo_held", NB + 12'h06A, 1'b1, 32'hFF12, 1'b0);
    rchk("current_value_lo_new", BK + 12'h06A, 1'b1, 32'h3456, 1'b0);
    load(16'hA5C3, 24'hABCDEF, 16'h8001);
    rchk("current_value_hi_held", NB + 12'h069, 1'b0, 32'h12, 1'b0);
    rchk("current_value_lo_byte", NB + 12'h06A, 1'b0, 32'h0, 1'b1);
    rchk("unmapped", NB + 12'h071, 1'b1, 32'h0, 1'b1);
    rchk("bad_window", 12'hD6E, 1'b0, 32'h0, 1'b1);
    // Cyclic trigger, period two: one start every third tick
    xfer(1'b1, NB + 12'h070, 1'b1, 4'h3, 32'h2);
    rchk("period", BK + 12'h070, 1'b1, 32'h2, 1'b0);
    xfer(1'b1, NB + 12'h070, 1'b0, 4'h1, 32'h5);
    chk("period_byte_err", 32'h1, {31'h0, er});
    rchk("period_kept", NB + 12'h070, 1'b1, 32'h2, 1'b0);
    lp_mode <= 1'b1;
    for (int i = 1; i <= 6; i++) begin
      tick();
      chk("start_cur", i / 3, n_cur);
    end
    chk("start_tmp", 32'h2, n_tmp);
    // Period zero runs continuously; a disabled channel stays quiet
    temp_en <= 1'b0;
    xfer(1'b1, NB + 12'h070, 1'b1, 4'h3, 32'h0);
    tick();
    tick();
    chk("cont_cur", 32'h4, n_cur);
    chk("cont_tmp", 32'h2, n_tmp);
    lp_mode <= 1'b0;
    tick();
    chk("no_lp", 32'h4, n_cur);
    final_report();
  end
endmodule : acqr_regs_tb
`default_nettype wire
